// [rtl/tick_pkg.sv]
// constants shared by the periodic tick interrupt timers
// assumes a classic wishbone register bus with 32-bit data
package tick_pkg;
  localparam logic [3:0] ADR_SRC0    = 4'h0;
  localparam logic [3:0] ADR_SRC1    = 4'h4;
  localparam logic [3:0] ADR_CTRL0   = 4'h8;
  localparam logic [3:0] ADR_CTRL1   = 4'hC;
  localparam logic [3:0] ADR_IRQCTL  = 4'h0;
  localparam int         ADR_W       = 5;
  localparam logic [4:0] ADR_IRQ     = 5'h10;
  localparam logic [4:0] ADR_STATUS  = 5'h14;
  localparam logic [4:0] ADR_MASK    = 5'h18;
  localparam int         ON_BIT      = 7;
  localparam int         PRE_LSB     = 4;
  localparam int         SEL_W       = 2;
  localparam int         PER_W       = 3;
  localparam int         PERIOD_BASE = 8;
  localparam int         SYS_DIV     = 4;
  localparam logic [1:0] SEL_SYS     = 2'h0;
  localparam logic [1:0] SEL_SYS4    = 2'h1;
  localparam logic [7:0] CTRL_RST    = 8'h00;
endpackage : tick_pkg

// [rtl/tick_sync.sv]
// two-flop synchroniser for a level from another clock domain
// assumes clk_i is the block clock
`timescale 1ns/1ps
`default_nettype none
module tick_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : tick_sync
`default_nettype wire

// [rtl/tick_gen.sv]
// one tick generator: source select, pre-divider and period divider
// assumes clock-source ticks arrive as one-cycle enables on clk_i
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int CNT_W = 23
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       on_i,
  input  wire logic       deep_sleep_i,
  input  wire logic       use_lirc_i,
  input  wire logic [1:0] source_i,
  input  wire logic [2:0] predivider_i,
  input  wire logic [2:0] period_i,
  input  wire logic       sys_tick_i,
  input  wire logic       sys4_tick_i,
  input  wire logic       sub_tick_i,
  input  wire logic       lirc_tick_i,
  output logic            overflow_o
);
  if (CNT_W < 23) begin : g_cnt_check
    $error("tick_gen counter too narrow");
  end
  logic             src_tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             first_q;
  logic [4:0]       expo;
  always_comb begin
    if (use_lirc_i && deep_sleep_i) src_tick = lirc_tick_i;
    else if (source_i[1]) src_tick = sub_tick_i;
    else if (source_i == tick_pkg::SEL_SYS4) src_tick = sys4_tick_i;
    else src_tick = sys_tick_i;
  end
  // total exponent = predivider + period base + period code
  assign expo = 5'(predivider_i) + 5'(tick_pkg::PERIOD_BASE) + 5'(period_i);
  assign cnt_d = cnt_q + CNT_W'(1);
  always_comb begin
    if (first_q && !deep_sleep_i)
      overflow_o = src_tick && (cnt_d == (CNT_W'(1) << (expo - 5'h1)));
    else
      overflow_o = src_tick && (cnt_d == (CNT_W'(1) << expo));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !on_i) begin
      cnt_q   <= '0;
      first_q <= 1'b1;
    end else if (overflow_o) begin
      cnt_q   <= '0;
      first_q <= 1'b0;
    end else if (src_tick) begin
      cnt_q <= cnt_d;
    end
  end
endmodule : tick_gen
`default_nettype wire

// [rtl/tick_timers.sv]
// periodic tick interrupt timers with wishbone registers
// assumes sub and low-speed clocks arrive as asynchronous pin levels
// Summary of operation
// - each generator overflow sets its own request flag
// - vector branch needs global enable and the generator's own enable
// - call only when enabled, stack not full, and overflow pending
// - servicing clears that request flag and the global enable
// - pre-divider (generator 0 only) and period bits set the divide ratio
// - source 0: 00 system, 01 system/4, 1x sub clock
// - source 1 uses the same encoding
// - deep sleep clocks generator 0 from the low-speed oscillator
// - source register bits 7 to 2 read as zero
// - period code 000..111 gives 2^8..2^15 prescaled periods
// - generator 1 on bit is bit 7, resets to zero
// - first interval after enable is half, outside deep sleep
`timescale 1ns/1ps
`default_nettype none
module tick_timers (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        sub_clock_i,
  input  wire logic        low_speed_internal_osc_i,
  input  wire logic        deep_sleep_i,
  input  wire logic        stack_full_i,
  input  wire logic        irq_ack_i,
  output logic             vector0_req_o,
  output logic             vector1_req_o,
  output logic             irq_o
);
  logic [1:0] src0_q, src1_q;
  logic [7:0] ctrl0_q, ctrl1_q;
  logic       global_irq_enable_q, tick0_irq_enable_q, tick1_irq_enable_q;
  logic [1:0] status_q, mask_q;
  logic [1:0] div4_q;
  logic       sub_s, sub_d_q, lirc_s, lirc_d_q, sleep_s;
  logic       sub_tick, lirc_tick, sys4_tick;
  logic [1:0] ovf;
  logic       wr, rd_ok, take0, take1;

  tick_sync u_sub (.clk_i(clk_i), .rst_i(rst_i), .d_i(sub_clock_i),
                   .q_o(sub_s));
  tick_sync u_lirc (.clk_i(clk_i), .rst_i(rst_i),
                    .d_i(low_speed_internal_osc_i), .q_o(lirc_s));
  tick_sync u_sleep (.clk_i(clk_i), .rst_i(rst_i), .d_i(deep_sleep_i),
                     .q_o(sleep_s));

  // rising edges of synchronised slow clocks, and a divide-by-four tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_d_q  <= 1'b0;
      lirc_d_q <= 1'b0;
      div4_q   <= 2'h0;
    end else begin
      sub_d_q  <= sub_s;
      lirc_d_q <= lirc_s;
      div4_q   <= div4_q + 2'h1;
    end
  end
  assign sub_tick  = sub_s & ~sub_d_q;
  assign lirc_tick = lirc_s & ~lirc_d_q;
  assign sys4_tick = (div4_q == 2'(tick_pkg::SYS_DIV - 1));

  tick_gen u_gen0 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .on_i         (ctrl0_q[tick_pkg::ON_BIT]),
    .deep_sleep_i (sleep_s),
    .use_lirc_i   (1'b1),
    .source_i     (src0_q),
    .predivider_i (ctrl0_q[6:4]),
    .period_i     (ctrl0_q[2:0]),
    .sys_tick_i   (1'b1),
    .sys4_tick_i  (sys4_tick),
    .sub_tick_i   (sub_tick),
    .lirc_tick_i  (lirc_tick),
    .overflow_o   (ovf[0])
  );
  tick_gen u_gen1 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .on_i         (ctrl1_q[tick_pkg::ON_BIT]),
    .deep_sleep_i (sleep_s),
    .use_lirc_i   (1'b0),
    .source_i     (src1_q),
    .predivider_i (3'h0),
    .period_i     (ctrl1_q[2:0]),
    .sys_tick_i   (1'b1),
    .sys4_tick_i  (sys4_tick),
    .sub_tick_i   (sub_tick),
    .lirc_tick_i  (lirc_tick),
    .overflow_o   (ovf[1])
  );

  assign wr    = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd_ok = cyc_i & stb_i & ~ack_o;

  // vector call: enables set, stack not full, flag pending
  assign vector0_req_o = global_irq_enable_q & tick0_irq_enable_q
                       & status_q[0] & ~stack_full_i;
  assign vector1_req_o = global_irq_enable_q & tick1_irq_enable_q
                       & status_q[1] & ~stack_full_i & ~vector0_req_o;
  assign take0 = irq_ack_i & vector0_req_o;
  assign take1 = irq_ack_i & vector1_req_o;
  assign irq_o = |(status_q & mask_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src0_q  <= 2'h0;
      src1_q  <= 2'h0;
      ctrl0_q <= tick_pkg::CTRL_RST;
      ctrl1_q <= tick_pkg::CTRL_RST;
      mask_q  <= 2'h0;
    end else if (wr) begin
      unique case (adr_i)
        5'(tick_pkg::ADR_SRC0): src0_q <= dat_i[1:0];
        5'(tick_pkg::ADR_SRC1): src1_q <= dat_i[1:0];
        5'(tick_pkg::ADR_CTRL0): ctrl0_q <= dat_i[7:0] & 8'hF7;
        5'(tick_pkg::ADR_CTRL1): ctrl1_q <= dat_i[7:0] & 8'h87;
        tick_pkg::ADR_MASK: mask_q <= dat_i[1:0];
        default: ;
      endcase
    end
  end

  // global and local enables; servicing drops the global enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable_q <= 1'b0;
      tick0_irq_enable_q  <= 1'b0;
      tick1_irq_enable_q  <= 1'b0;
    end else begin
      if (take0 || take1) global_irq_enable_q <= 1'b0;
      else if (wr && adr_i == tick_pkg::ADR_IRQ)
        global_irq_enable_q <= dat_i[0];
      if (wr && adr_i == tick_pkg::ADR_IRQ) begin
        tick0_irq_enable_q <= dat_i[1];
        tick1_irq_enable_q <= dat_i[2];
      end
    end
  end

  // sticky flags: overflow set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ovf[i]) status_q[i] <= 1'b1;
        else if ((i == 0 && take0) || (i == 1 && take1))
          status_q[i] <= 1'b0;
        else if (wr && adr_i == tick_pkg::ADR_STATUS && dat_i[i])
          status_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= rd_ok;
      dat_o <= 32'h0000_0000;
      if (rd_ok) begin
        unique case (adr_i)
          5'(tick_pkg::ADR_SRC0): dat_o <= {30'h0, src0_q};
          5'(tick_pkg::ADR_SRC1): dat_o <= {30'h0, src1_q};
          5'(tick_pkg::ADR_CTRL0): dat_o <= {24'h0, ctrl0_q};
          5'(tick_pkg::ADR_CTRL1): dat_o <= {24'h0, ctrl1_q};
          tick_pkg::ADR_IRQ: dat_o <= {29'h0, tick1_irq_enable_q,
                                       tick0_irq_enable_q,
                                       global_irq_enable_q};
          tick_pkg::ADR_STATUS: dat_o <= {30'h0, status_q};
          tick_pkg::ADR_MASK: dat_o <= {30'h0, mask_q};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : tick_timers
`default_nettype wire

// [tb/tick_timers_monitor.sv]
// port assertions for the tick timers
// assumes one clock domain, bound into tick_timers
`timescale 1ns/1ps
`default_nettype none
module tick_timers_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        stack_full_i,
  input wire logic        irq_ack_i,
  input wire logic        vector0_req_o,
  input wire logic        vector1_req_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  assign rd = ack_o && !we_i;
  property p_ack_one; ack_o |=> !ack_o; endproperty
  property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  property p_src; rd && adr_i < 5'h08 |-> dat_o[31:2] == 30'h0; endproperty
  property p_ctl0;
    rd && adr_i == 5'h08 |-> dat_o[31:8] == 24'h0 && !dat_o[3];
  endproperty
  property p_ctl1; rd && adr_i == 5'h0C |-> dat_o[6:3] == 4'h0; endproperty
  property p_unmap; rd && adr_i > 5'h18 |-> dat_o == 32'h0; endproperty
  property p_stack; stack_full_i |-> !vector0_req_o && !vector1_req_o;
  endproperty
  property p_serve;
    irq_ack_i && vector0_req_o |=> !vector0_req_o && !vector1_req_o;
  endproperty
  property p_prio; vector0_req_o |-> !vector1_req_o; endproperty
  property p_rst; $fell(rst_i) |-> !irq_o && !vector0_req_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack late");
  a_src: assert property (p_src)
    else $error("source upper bits not zero");
  a_ctl0: assert property (p_ctl0)
    else $error("control 0 spare bits set");
  a_ctl1: assert property (p_ctl1)
    else $error("control 1 spare bits set");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_stack: assert property (p_stack)
    else $error("vector with full stack");
  a_serve: assert property (p_serve)
    else $error("vector after service");
  a_prio: assert property (p_prio)
    else $error("two vectors at once");
  a_rst: assert property (p_rst)
    else $error("request after reset");
  c_rd: cover property (rd && adr_i < 5'h08);
  c_serve: cover property (irq_ack_i && vector0_req_o);
  c_irq: cover property (irq_o);
endmodule : tick_timers_monitor
bind tick_timers tick_timers_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
  .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
  .vector0_req_o(vector0_req_o), .vector1_req_o(vector1_req_o));
`default_nettype wire

// [tb/tick_timers_bench.sv]
// self-checking bench for the tick timers over wishbone
// assumes bench-made slow clocks and a bench-driven deep sleep level
`timescale 1ns/1ps
`default_nettype none
module tick_timers_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sfull = 1'b0, iack = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic        ack, v0, v1, irq;
  logic [1:0]  slow_q = 2'h0;
  logic        sleep = 1'b0;
  int          failures = 0, num_checks = 0, cycles = 0;
  localparam logic [4:0] ST = tick_pkg::ADR_STATUS;
  localparam logic [4:0] IC = tick_pkg::ADR_IRQ;
  tick_timers i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r),
    .ack_o(ack), .sub_clock_i(slow_q[0]),
    .low_speed_internal_osc_i(slow_q[1]),
    .deep_sleep_i(sleep), .stack_full_i(sfull), .irq_ack_i(iack),
    .vector0_req_o(v0), .vector1_req_o(v1), .irq_o(irq));
  always #2 clk_i = ~clk_i;
  // sub clock rises every 2 cycles, low-speed oscillator every 4
  always @(posedge clk_i) slow_q <= slow_q + 2'h1;
  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pin(ref logic s, input logic e);
    @(negedge clk_i);
    chk({31'h0, s}, {31'h0, e});
    @(posedge clk_i);
  endtask : pin
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    // wait for ack at a rising edge; only the bench timeout ends a hang
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) rd(5'(4 * i), 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(5'(4 * i), 32'hFF);
      rd(5'(4 * i), 32'h3);
    end
    wr(5'h08, 32'hFF);
    rd(5'h08, 32'hF7);
    wr(5'h0C, 32'hFF);
    rd(5'h0C, 32'h87);
    wr(5'h1C, 32'hFF);
    rd(5'h1C, 32'h0);
    wr(5'h08, 32'h0);
    wr(5'h0C, 32'h0);
    wr(5'h00, 32'h0);
    wr(5'h08, 32'h80);
    repeat (100) @(posedge clk_i);
    rd(ST, 32'h0);
    repeat (100) @(posedge clk_i);
    rd(ST, 32'h1);
    sfull <= 1'b1;
    wr(IC, 32'h3);
    pin(v0, 1'b0);
    sfull <= 1'b0;
    pin(v0, 1'b1);
    pin(v1, 1'b0);
    wr(tick_pkg::ADR_MASK, 32'h1);
    pin(irq, 1'b1);
    iack <= 1'b1;
    @(posedge clk_i);
    iack <= 1'b0;
    rd(ST, 32'h0);
    rd(IC, 32'h2);
    pin(irq, 1'b0);
    wr(5'h08, 32'h0);
    repeat (400) @(posedge clk_i);
    rd(ST, 32'h0);
    wr(5'h04, 32'h1);
    wr(5'h0C, 32'h80);
    repeat (400) @(posedge clk_i);
    rd(ST, 32'h0);
    repeat (300) @(posedge clk_i);
    rd(ST, 32'h2);
    pin(irq, 1'b0);
    wr(IC, 32'h5);
    pin(v1, 1'b1);
    wr(5'h0C, 32'h0);
    wr(ST, 32'h2);
    rd(ST, 32'h0);
    pin(v1, 1'b0);
    wr(5'h00, 32'h2);
    wr(5'h08, 32'h80);
    repeat (200) @(posedge clk_i);
    rd(ST, 32'h0);
    repeat (100) @(posedge clk_i);
    rd(ST, 32'h1);
    sleep <= 1'b1;
    wr(5'h08, 32'h0);
    wr(ST, 32'h1);
    wr(5'h08, 32'h80);
    repeat (700) @(posedge clk_i);
    rd(ST, 32'h0);
    repeat (400) @(posedge clk_i);
    rd(ST, 32'h1);
    close_out();
  end
endmodule : tick_timers_bench
`default_nettype wire
